// ==== core/cit_consts.svh ====
// Timing, memory size and encoding constants for the instruction timing core
`ifndef CIT_CONSTS_SVH
`define CIT_CONSTS_SVH

`define CIT_MCLK_HZ 100000000
`define CIT_CORE_MAX_HZ 25000000
`define CIT_CORE_DIV ((`CIT_MCLK_HZ + `CIT_CORE_MAX_HZ - 1) / `CIT_CORE_MAX_HZ)

`define CIT_MAX_CYCLES 8
`define CIT_CYC_DIV 4'h8
`define CIT_CYC_MUL 4'h4
`define CIT_CYC_RET 4'h5
`define CIT_CYC_XMOVE 4'h3
`define CIT_CYC_LONG 4'h4
`define CIT_INSTR_COUNT 109
`define CIT_RESERVED_OP 8'ha5

`define CIT_IRAM_BYTES 256
`define CIT_SFR_BYTES 128
`define CIT_SFR_BASE 8'h80
`define CIT_ON_CHIP_EXPANSION_RAM_BYTES 512
`define CIT_NUM_BP 4

`endif

// ==== core/cit_pkg.sv ====
// Types shared by the instruction timing core
package cit_pkg;

  typedef enum logic [1:0] {
    CIT_ST_FETCH = 2'b00,
    CIT_ST_EXEC = 2'b01,
    CIT_ST_HALT = 2'b11
  } cit_state_type;

endpackage

// ==== core/cit_decode.sv ====
// Opcode length and cycle table
`timescale 1ns/1ps
`include "cit_consts.svh"

module cit_decode
(
  input wire logic [7:0] opcode_i,
  output logic [1:0] bytes_o,
  output logic [3:0] cycles_o,
  output logic cond_o,
  output logic legal_o
);

  // Cycles are the not-taken figure; a taken branch adds one
  always_comb
  begin
    bytes_o = 2'h1;
    cycles_o = 4'h1;
    cond_o = 1'b0;
    legal_o = 1'b1;
    casez (opcode_i) // RULE5
      `CIT_RESERVED_OP:
        legal_o = 1'b0; // RULE6
      8'h02, 8'h12:
      begin
        bytes_o = 2'h3;
        cycles_o = `CIT_CYC_LONG;
      end
      8'h22, 8'h32:
        cycles_o = `CIT_CYC_RET; // RULE19
      8'he0, 8'hf0, 8'he2, 8'he3, 8'hf2, 8'hf3:
        cycles_o = `CIT_CYC_XMOVE; // RULE20
      8'h73, 8'h83, 8'h93:
        cycles_o = 4'h3;
      8'h84:
        cycles_o = `CIT_CYC_DIV; // RULE4
      8'ha4:
        cycles_o = `CIT_CYC_MUL; // RULE4
      8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90:
      begin
        bytes_o = 2'h3; // RULE10
        cycles_o = 4'h3;
      end
      8'h10, 8'h20, 8'h30, 8'hb4, 8'hb5, 8'hd5, 8'b1011_1???:
      begin
        bytes_o = 2'h3;
        cycles_o = 4'h3;
        cond_o = 1'b1; // RULE3
      end
      8'hb6, 8'hb7:
      begin
        bytes_o = 2'h3;
        cycles_o = 4'h4;
        cond_o = 1'b1;
      end
      8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???:
      begin
        bytes_o = 2'h2;
        cycles_o = 4'h2;
        cond_o = 1'b1; // RULE18
      end
      8'h80, 8'b????_0001:
      begin
        bytes_o = 2'h2;
        cycles_o = 4'h3;
      end
      8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'ha2, 8'hb2, 8'hc2, 8'hd2,
      8'ha0, 8'hb0, 8'hc0, 8'hd0, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94,
      8'h76, 8'h77, 8'h86, 8'h87, 8'ha6, 8'ha7,
      8'b0111_1???, 8'b1000_1???, 8'b1010_1???, 8'b????_0101:
      begin
        bytes_o = 2'h2; // RULE7 RULE8 RULE11
        cycles_o = 4'h2;
      end
      8'b????_011?:
        cycles_o = 4'h2; // RULE7 RULE8 RULE11
      default:
        cycles_o = 4'h1; // RULE9 RULE10
    endcase
  end

endmodule

// ==== core/cit_core.sv ====
// Cycle timing, debug control and on-chip memory routing of the 8-bit core
//
// Behaviour
// RULE1 - Count execution in single core clock cycles, never in machine cycles.
// RULE2 - Most instructions take as many cycles as they have program bytes.
// RULE3 - A conditional branch not taken ends one cycle sooner than taken.
// RULE4 - No instruction exceeds eight cycles; divide takes eight, multiply four.
// RULE5 - Opcodes, addressing modes and flag effects follow the standard set.
// RULE6 - The repertoire holds 109 distinct instructions.
// RULE7 - Add forms: register 1/1, direct or immediate 2/2, indirect 1/2.
// RULE8 - Increment and decrement: A or register 1, direct 2/2, indirect 1/2.
// RULE9 - Data pointer increment is one byte and one cycle.
// RULE10 - Logic to direct with immediate is 3/3; register into A is 1/1.
// RULE11 - Logic into A: indirect 1/2, direct or immediate 2/2.
// RULE12 - External-space moves go to expansion RAM or flash; no off-chip bus.
// RULE13 - Software reads and writes flash bytewise via code and external moves.
// RULE14 - Core runs from zero to 25 MHz, one instruction per cycle at peak.
// RULE15 - 256 bytes of internal RAM and a 128-byte special register space.
// RULE16 - Debug host sets breakpoints, runs, stops and steps, ISRs included.
// RULE17 - Debug logic uses no application RAM, stack, timers or resources.
// RULE18 - Two-byte carry branch: two cycles not taken, three taken.
// RULE19 - Both returns are one byte and five cycles.
// RULE20 - Every external-space move is one byte and three cycles.
// RULE21 - A stall holds the next opcode fetch until the last cycle completes.
`timescale 1ns/1ps
`include "cit_consts.svh"

module cit_core
#(
  parameter int NUM_BP = `CIT_NUM_BP,
  parameter int ON_CHIP_EXPANSION_RAM_BYTES = `CIT_ON_CHIP_EXPANSION_RAM_BYTES,
  parameter int CORE_DIV = `CIT_CORE_DIV,
  parameter int MAX_CYCLES = `CIT_MAX_CYCLES
)
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic stall_i,
  input wire logic op_valid_i,
  input wire logic [7:0] op_i,
  input wire logic [15:0] pc_i,
  input wire logic branch_taken_i,
  output logic op_ready_o,
  output logic core_ce_o,
  output logic opnd_fetch_o,
  output logic busy_o,
  output logic [3:0] cycle_o,
  output logic instr_done_o,
  output logic [3:0] instr_cycles_o,
  output logic [1:0] instr_bytes_o,
  output logic illegal_o,
  output logic [31:0] instr_count_o,
  output logic [31:0] cycle_count_o,
  input wire logic halt_req_i,
  input wire logic run_req_i,
  input wire logic step_req_i,
  input wire logic bp_wr_i,
  input wire logic [$clog2(NUM_BP)-1:0] bp_idx_i,
  input wire logic [15:0] bp_addr_i,
  input wire logic bp_en_i,
  output logic halted_o,
  output logic bp_hit_o,
  input wire logic dmem_req_i,
  input wire logic dmem_wr_i,
  input wire logic dmem_indirect_i,
  input wire logic [7:0] dmem_addr_i,
  input wire logic [7:0] dmem_wdata_i,
  output logic dmem_ack_o,
  output logic [7:0] dmem_rdata_o,
  output logic sfr_rd_o,
  output logic sfr_wr_o,
  output logic [6:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i,
  input wire logic xmove_req_i,
  input wire logic xmove_wr_i,
  input wire logic [15:0] xmove_addr_i,
  input wire logic [7:0] xmove_wdata_i,
  input wire logic flash_sel_i,
  output logic xmove_ack_o,
  input wire logic cmove_req_i,
  input wire logic [15:0] cmove_addr_i,
  output logic cmove_ack_o,
  output logic [7:0] far_rdata_o,
  output logic flash_rd_o,
  output logic flash_wr_o,
  output logic [15:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  input wire logic [7:0] flash_rdata_i
);

  localparam int DIV_W = (CORE_DIV > 1) ? $clog2(CORE_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CORE_DIV - 1);
  localparam int XAW = $clog2(ON_CHIP_EXPANSION_RAM_BYTES);

  // Memory stages take two mclk edges, so a core cycle must span at least two
  if (CORE_DIV < 2) $error("CORE_DIV must be at least 2");
  if (NUM_BP < 2 || NUM_BP > 16) $error("NUM_BP must be 2 to 16");
  if (ON_CHIP_EXPANSION_RAM_BYTES < 2 || ON_CHIP_EXPANSION_RAM_BYTES > 65536 || (ON_CHIP_EXPANSION_RAM_BYTES & (ON_CHIP_EXPANSION_RAM_BYTES - 1)) != 0)
    $error("ON_CHIP_EXPANSION_RAM_BYTES must be a power of two up to 65536");
  if (MAX_CYCLES != `CIT_MAX_CYCLES) $error("Cycle table assumes an eight-cycle ceiling");

  typedef struct packed {
    cit_pkg::cit_state_type st;
    logic [DIV_W-1:0] div;
    logic [3:0] cyc;
    logic [3:0] total;
    logic [1:0] bytes;
    logic cond;
    logic halt_pend;
    logic step_pend;
    logic skip_bp;
    logic done;
    logic [3:0] done_cycles;
    logic [1:0] done_bytes;
    logic illegal;
    logic bp_hit;
    logic [31:0] instr_cnt;
    logic [31:0] cycle_cnt;
    logic [NUM_BP-1:0][15:0] bp_addr;
    logic [NUM_BP-1:0] bp_en;
    logic [`CIT_IRAM_BYTES-1:0][7:0] iram;
    logic d1_vld;
    logic d1_sfr;
    logic d1_wr;
    logic [7:0] d1_addr;
    logic [7:0] d1_wdata;
    logic dack;
    logic [7:0] drdata;
    logic [ON_CHIP_EXPANSION_RAM_BYTES-1:0][7:0] on_chip_expansion_ram;
    logic f1_vld;
    logic f1_flash;
    logic f1_wr;
    logic f1_code;
    logic [15:0] f1_addr;
    logic [7:0] f1_wdata;
    logic xack;
    logic cack;
    logic [7:0] frdata;
  } cit_core_state_type;

  cit_core_state_type s_ff;
  cit_core_state_type nxt_s;

  logic [1:0] dec_bytes;
  logic [3:0] dec_cycles;
  logic dec_cond;
  logic dec_legal;
  logic ce;
  logic go;
  logic bp_match;
  logic bp_stop;
  logic accept;
  logic fin;
  logic [3:0] fin_cycles;

  cit_decode u_decode
  (
    .opcode_i(op_i),
    .bytes_o(dec_bytes),
    .cycles_o(dec_cycles),
    .cond_o(dec_cond),
    .legal_o(dec_legal)
  );

  // Breakpoints live in their own flops, never in application memory
  always_comb
  begin
    bp_match = 1'b0;
    for (int i = 0; i < NUM_BP; i++)
    begin
      if (s_ff.bp_en[i] && (s_ff.bp_addr[i] == pc_i))
        bp_match = 1'b1; // RULE16 RULE17
    end
  end

  // One core cycle per enable pulse; the divider keeps the core at or below 25 MHz
  assign ce = (s_ff.div == DIV_LAST); // RULE14 RULE1
  assign go = ce & ~stall_i; // RULE21
  assign bp_stop = op_valid_i & bp_match & ~s_ff.skip_bp;
  assign accept = op_ready_o & op_valid_i;

  always_comb
  begin
    op_ready_o = 1'b0;
    if ((s_ff.st == cit_pkg::CIT_ST_FETCH) && go && !bp_stop && !halt_req_i && !s_ff.halt_pend)
      op_ready_o = 1'b1; // RULE21
  end

  // Remaining program bytes are fetched one per cycle after the opcode
  assign opnd_fetch_o = (s_ff.st == cit_pkg::CIT_ST_EXEC) && go && (s_ff.cyc < 4'(s_ff.bytes)); // RULE2

  always_comb
  begin
    nxt_s = s_ff;
    fin = 1'b0;
    fin_cycles = 4'h1;
    nxt_s.done = 1'b0;
    nxt_s.bp_hit = 1'b0;
    nxt_s.dack = 1'b0;
    nxt_s.xack = 1'b0;
    nxt_s.cack = 1'b0;
    nxt_s.div = ce ? '0 : s_ff.div + 1'b1;
    if (ce && s_ff.st != cit_pkg::CIT_ST_HALT)
      nxt_s.cycle_cnt = s_ff.cycle_cnt + 32'h1; // RULE1

    case (s_ff.st)
      cit_pkg::CIT_ST_FETCH:
      begin
        if (halt_req_i || s_ff.halt_pend)
        begin
          nxt_s.st = cit_pkg::CIT_ST_HALT; // RULE16
          nxt_s.halt_pend = 1'b0;
        end
        else if (go && bp_stop)
        begin
          nxt_s.st = cit_pkg::CIT_ST_HALT; // RULE16
          nxt_s.bp_hit = 1'b1;
        end
        else if (accept)
        begin
          nxt_s.skip_bp = 1'b0;
          nxt_s.cyc = 4'h1;
          nxt_s.total = dec_cycles; // RULE4
          nxt_s.bytes = dec_bytes;
          nxt_s.cond = dec_cond;
          nxt_s.illegal = ~dec_legal; // RULE6
          if (dec_cycles == 4'h1)
            fin = 1'b1; // RULE2
          else
            nxt_s.st = cit_pkg::CIT_ST_EXEC;
        end
      end
      cit_pkg::CIT_ST_EXEC:
      begin
        if (halt_req_i)
          nxt_s.halt_pend = 1'b1;
        if (go)
        begin
          // The branch outcome is sampled in the last not-taken cycle
          if (s_ff.cond && (s_ff.cyc == s_ff.total - 4'h1) && branch_taken_i)
          begin
            nxt_s.cond = 1'b0; // RULE3 RULE18
            nxt_s.total = s_ff.total + 4'h1;
            nxt_s.cyc = s_ff.cyc + 4'h1;
          end
          else if (s_ff.cyc + 4'h1 == s_ff.total)
          begin
            fin = 1'b1; // RULE21
            fin_cycles = s_ff.total;
          end
          else
            nxt_s.cyc = s_ff.cyc + 4'h1;
        end
      end
      cit_pkg::CIT_ST_HALT:
      begin
        nxt_s.halt_pend = 1'b0;
        // Resuming skips the breakpoint the core stopped on
        if (run_req_i)
        begin
          nxt_s.st = cit_pkg::CIT_ST_FETCH; // RULE16
          nxt_s.skip_bp = 1'b1;
        end
        else if (step_req_i)
        begin
          nxt_s.st = cit_pkg::CIT_ST_FETCH; // RULE16
          nxt_s.step_pend = 1'b1;
          nxt_s.skip_bp = 1'b1;
        end
      end
      default:
        nxt_s.st = cit_pkg::CIT_ST_FETCH;
    endcase

    // Stepping counts any instruction, interrupt handlers included
    if (fin)
    begin
      nxt_s.done = 1'b1;
      nxt_s.done_cycles = fin_cycles;
      nxt_s.done_bytes = (s_ff.st == cit_pkg::CIT_ST_FETCH) ? dec_bytes : s_ff.bytes;
      nxt_s.instr_cnt = s_ff.instr_cnt + 32'h1;
      nxt_s.cyc = 4'h0;
      nxt_s.cond = 1'b0;
      if (s_ff.step_pend || s_ff.halt_pend || halt_req_i)
        nxt_s.st = cit_pkg::CIT_ST_HALT; // RULE16
      else
        nxt_s.st = cit_pkg::CIT_ST_FETCH;
      nxt_s.step_pend = 1'b0;
      nxt_s.halt_pend = 1'b0;
    end

    if (bp_wr_i)
    begin
      nxt_s.bp_addr[bp_idx_i] = bp_addr_i; // RULE16
      nxt_s.bp_en[bp_idx_i] = bp_en_i;
    end

    // Direct upper half is special register space, indirect upper half is RAM
    if (s_ff.d1_vld)
    begin
      nxt_s.dack = 1'b1;
      if (s_ff.d1_sfr)
        nxt_s.drdata = s_ff.d1_wr ? s_ff.d1_wdata : sfr_rdata_i; // RULE15
      else if (s_ff.d1_wr)
      begin
        nxt_s.iram[s_ff.d1_addr] = s_ff.d1_wdata; // RULE15
        nxt_s.drdata = s_ff.d1_wdata;
      end
      else
        nxt_s.drdata = s_ff.iram[s_ff.d1_addr];
    end
    nxt_s.d1_vld = dmem_req_i;
    if (dmem_req_i)
    begin
      nxt_s.d1_sfr = ~dmem_indirect_i & (dmem_addr_i >= `CIT_SFR_BASE); // RULE15
      nxt_s.d1_wr = dmem_wr_i;
      nxt_s.d1_addr = dmem_addr_i;
      nxt_s.d1_wdata = dmem_wdata_i;
    end

    // Far accesses stay on chip; expansion RAM wraps on its own size
    if (s_ff.f1_vld)
    begin
      nxt_s.xack = ~s_ff.f1_code;
      nxt_s.cack = s_ff.f1_code;
      if (s_ff.f1_flash)
        nxt_s.frdata = s_ff.f1_wr ? s_ff.f1_wdata : flash_rdata_i; // RULE13
      else if (s_ff.f1_wr)
      begin
        nxt_s.on_chip_expansion_ram[s_ff.f1_addr[XAW-1:0]] = s_ff.f1_wdata; // RULE12
        nxt_s.frdata = s_ff.f1_wdata;
      end
      else
        nxt_s.frdata = s_ff.on_chip_expansion_ram[s_ff.f1_addr[XAW-1:0]];
    end
    nxt_s.f1_vld = xmove_req_i | cmove_req_i;
    // External move wins when both arrive together
    if (xmove_req_i)
    begin
      nxt_s.f1_code = 1'b0;
      nxt_s.f1_flash = flash_sel_i; // RULE12
      nxt_s.f1_wr = xmove_wr_i;
      nxt_s.f1_addr = xmove_addr_i;
      nxt_s.f1_wdata = xmove_wdata_i;
    end
    else if (cmove_req_i)
    begin
      nxt_s.f1_code = 1'b1;
      nxt_s.f1_flash = 1'b1; // RULE13
      nxt_s.f1_wr = 1'b0;
      nxt_s.f1_addr = cmove_addr_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign core_ce_o = ce;
  assign busy_o = (s_ff.st == cit_pkg::CIT_ST_EXEC);
  assign cycle_o = s_ff.cyc;
  assign instr_done_o = s_ff.done;
  assign instr_cycles_o = s_ff.done_cycles;
  assign instr_bytes_o = s_ff.done_bytes;
  assign illegal_o = s_ff.illegal;
  assign instr_count_o = s_ff.instr_cnt;
  assign cycle_count_o = s_ff.cycle_cnt;
  assign halted_o = (s_ff.st == cit_pkg::CIT_ST_HALT);
  assign bp_hit_o = s_ff.bp_hit;
  assign dmem_ack_o = s_ff.dack;
  assign dmem_rdata_o = s_ff.drdata;
  assign sfr_rd_o = s_ff.d1_vld & s_ff.d1_sfr & ~s_ff.d1_wr;
  assign sfr_wr_o = s_ff.d1_vld & s_ff.d1_sfr & s_ff.d1_wr;
  assign sfr_addr_o = s_ff.d1_addr[6:0];
  assign sfr_wdata_o = s_ff.d1_wdata;
  assign xmove_ack_o = s_ff.xack;
  assign cmove_ack_o = s_ff.cack;
  assign far_rdata_o = s_ff.frdata;
  assign flash_rd_o = s_ff.f1_vld & s_ff.f1_flash & ~s_ff.f1_wr;
  assign flash_wr_o = s_ff.f1_vld & s_ff.f1_flash & s_ff.f1_wr;
  assign flash_addr_o = s_ff.f1_addr;
  assign flash_wdata_o = s_ff.f1_wdata;

endmodule

// ==== test/cit_core_properties.sv ====
// Assertions on core timing, debug and memory routing
`timescale 1ns/1ps
module cit_core_properties
#(
  parameter int CORE_DIV = 4
)
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic stall_i,
  input wire logic op_ready_o,
  input wire logic core_ce_o,
  input wire logic busy_o,
  input wire logic instr_done_o,
  input wire logic [3:0] instr_cycles_o,
  input wire logic [1:0] instr_bytes_o,
  input wire logic halted_o,
  input wire logic dmem_req_i,
  input wire logic dmem_wr_i,
  input wire logic dmem_indirect_i,
  input wire logic [7:0] dmem_addr_i,
  input wire logic dmem_ack_o,
  input wire logic sfr_rd_o,
  input wire logic [6:0] sfr_addr_o,
  input wire logic xmove_req_i,
  input wire logic xmove_wr_i,
  input wire logic [15:0] xmove_addr_i,
  input wire logic flash_sel_i,
  input wire logic flash_rd_o,
  input wire logic flash_wr_o,
  input wire logic [15:0] flash_addr_o
);
  logic [7:0] cnt_ff;
  // Clocks since the last core enable
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i || core_ce_o)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + 8'h01;
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  a_ce_period: assert property (core_ce_o == (cnt_ff == 8'(CORE_DIV - 1)))
    else $error("core enable period wrong");
  a_done_pulse: assert property (instr_done_o |=> !instr_done_o)
    else $error("done wider than one clock");
  a_cycles_max: assert property (instr_done_o |-> instr_cycles_o inside {[4'h1:4'h8]})
    else $error("cycle count out of range");
  a_cycles_bytes: assert property (instr_done_o |-> instr_cycles_o >= 4'(instr_bytes_o))
    else $error("fewer cycles than bytes");
  a_take_on_ce: assert property (op_ready_o |-> core_ce_o && !stall_i)
    else $error("opcode taken off enable or in stall");
  a_busy_no_take: assert property (busy_o |-> !op_ready_o)
    else $error("opcode taken while busy");
  a_halt_no_take: assert property (halted_o |-> !op_ready_o)
    else $error("opcode taken while halted");
  a_dmem_ack: assert property (dmem_req_i |-> ##2 dmem_ack_o)
    else $error("data ack late");
  a_sfr_read: assert property (dmem_req_i && !dmem_wr_i && !dmem_indirect_i &&
    dmem_addr_i[7] |=> sfr_rd_o && sfr_addr_o == 7'($past(dmem_addr_i)))
    else $error("special register read missing");
  a_flash_read: assert property (xmove_req_i && flash_sel_i && !xmove_wr_i
    |=> flash_rd_o && flash_addr_o == $past(xmove_addr_i))
    else $error("flash read missing");
  a_on_chip_expansion_ram_only: assert property (xmove_req_i && !flash_sel_i |=> !flash_rd_o && !flash_wr_o)
    else $error("expansion access hit flash");
endmodule

bind cit_core cit_core_properties #(.CORE_DIV(CORE_DIV)) i_props (.*);

// ==== test/cit_mem_model.sv ====
// Flash and special register responder for the core bench
`timescale 1ns/1ps
module cit_mem_model
(
  input wire logic mclk_i,
  input wire logic flash_rd_i,
  input wire logic flash_wr_i,
  input wire logic [15:0] flash_addr_i,
  input wire logic [7:0] flash_wdata_i,
  output logic [7:0] flash_rdata_o,
  input wire logic sfr_rd_i,
  input wire logic sfr_wr_i,
  input wire logic [6:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o
);
  logic [7:0] flash_mem [256];
  logic [7:0] sfr_mem [128];
  logic [7:0] pat_ff = 8'h00;
  initial
  begin
    foreach (flash_mem[i]) flash_mem[i] = 8'hff;
    foreach (sfr_mem[i]) sfr_mem[i] = 8'h00;
  end
  // Unselected data wanders so a stale byte never passes for an answer
  assign flash_rdata_o = flash_rd_i ? flash_mem[flash_addr_i[7:0]] : pat_ff;
  assign sfr_rdata_o = sfr_rd_i ? sfr_mem[sfr_addr_i] : ~pat_ff;
  always @(posedge mclk_i)
  begin
    pat_ff <= pat_ff + 8'h35;
    if (flash_wr_i)
      flash_mem[flash_addr_i[7:0]] <= flash_wdata_i;
    if (sfr_wr_i)
      sfr_mem[sfr_addr_i] <= sfr_wdata_i;
  end
endmodule

// ==== test/cit_core_tb_top.sv ====
// Self-checking bench for the instruction timing core
`timescale 1ns/1ps
module cit_core_tb_top;
  localparam int DIV = 4;
  logic mclk_i = 1'h0, resetn_i = 1'h0, stall_i = 1'h0, op_valid_i = 1'h0;
  logic branch_taken_i = 1'h0, halt_req_i = 1'h0, run_req_i = 1'h0, step_req_i = 1'h0;
  logic bp_wr_i = 1'h0, bp_en_i = 1'h0, dmem_req_i = 1'h0, dmem_wr_i = 1'h0;
  logic dmem_indirect_i = 1'h0, xmove_req_i = 1'h0, xmove_wr_i = 1'h0;
  logic flash_sel_i = 1'h0, cmove_req_i = 1'h0;
  logic [1:0] bp_idx_i = 2'h0;
  logic [7:0] op_i = 8'h00, dmem_addr_i = 8'h00, dmem_wdata_i = 8'h00, xmove_wdata_i = 8'h00;
  logic [15:0] pc_i = 16'h0000, bp_addr_i = 16'h0000;
  logic [15:0] xmove_addr_i = 16'h0000, cmove_addr_i = 16'h0000;
  logic op_ready_o, core_ce_o, opnd_fetch_o, busy_o, instr_done_o, illegal_o, halted_o;
  logic bp_hit_o, dmem_ack_o, sfr_rd_o, sfr_wr_o, xmove_ack_o, cmove_ack_o;
  logic flash_rd_o, flash_wr_o;
  logic [1:0] instr_bytes_o;
  logic [3:0] cycle_o, instr_cycles_o;
  logic [6:0] sfr_addr_o;
  logic [7:0] dmem_rdata_o, sfr_wdata_o, sfr_rdata_i, far_rdata_o, flash_wdata_o, flash_rdata_i;
  logic [15:0] flash_addr_o;
  logic [31:0] instr_count_o, cycle_count_o;
  int fails = 0, compares = 0;
  // Opcode, cycles, bytes, branch taken
  logic [19:0] tbl [27] = '{20'h00110, 20'h28110, 20'h25220, 20'h26210, 20'h24220,
    20'h35220, 20'h96210, 20'h04110, 20'h05220, 20'h16210, 20'ha3110, 20'ha4410, 20'h84810,
    20'h43330, 20'h53330, 20'h63330, 20'h58110, 20'h56210, 20'h44220, 20'h22510, 20'h32510,
    20'he0310, 20'hf2310, 20'h40220, 20'h40321, 20'h93310, 20'ha5110};

  cit_core #(.CORE_DIV(DIV)) i_dut (.*);
  cit_mem_model i_mem (.mclk_i(mclk_i), .flash_rd_i(flash_rd_o), .flash_wr_i(flash_wr_o),
    .flash_addr_i(flash_addr_o), .flash_wdata_i(flash_wdata_o), .flash_rdata_o(flash_rdata_i),
    .sfr_rd_i(sfr_rd_o), .sfr_wr_i(sfr_wr_o), .sfr_addr_i(sfr_addr_o),
    .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i));

  always #5 mclk_i = ~mclk_i;

  task automatic cmp(input logic [31:0] g, e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic abort();
    fails++;
    conclude();
  endtask

  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge mclk_i);
    s = 1'h0;
  endtask

  // Latency counts clocks from acceptance to done, so enable phase cancels out
  task automatic run_op(input logic [7:0] op, input logic tk, output int lat, fc);
    int n;
    n = 0;
    fc = 0;
    lat = 1;
    op_i = op;
    branch_taken_i = tk;
    op_valid_i = 1'h1;
    #1;
    while (op_ready_o !== 1'h1 && n < 100)
    begin
      @(negedge mclk_i);
      #1;
      n++;
    end
    @(negedge mclk_i);
    op_valid_i = 1'h0;
    #1;
    while (instr_done_o !== 1'h1 && lat < 200)
    begin
      fc += (opnd_fetch_o === 1'h1);
      @(negedge mclk_i);
      #1;
      lat++;
    end
    if (n >= 100 || lat >= 200)
      abort();
    @(negedge mclk_i);
  endtask

  task automatic idle_chk(input logic [15:0] pc, output int rdy, hit);
    pc_i = pc;
    op_i = 8'h00;
    op_valid_i = 1'h1;
    rdy = 0;
    hit = 0;
    repeat (20)
    begin
      @(negedge mclk_i);
      rdy += (op_ready_o === 1'h1);
      hit += (bp_hit_o === 1'h1);
    end
    op_valid_i = 1'h0;
  endtask

  task automatic acc(input int k, input logic wr, ind, input logic [15:0] a,
    input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    {dmem_req_i, xmove_req_i, cmove_req_i} = {k == 0, k == 1, k == 2};
    {dmem_wr_i, xmove_wr_i, dmem_indirect_i} = {wr, wr, ind};
    {dmem_addr_i, xmove_addr_i, cmove_addr_i} = {a[7:0], a, a};
    {dmem_wdata_i, xmove_wdata_i} = {wd, wd};
    @(negedge mclk_i);
    {dmem_req_i, xmove_req_i, cmove_req_i} = 3'h0;
    while ((dmem_ack_o | xmove_ack_o | cmove_ack_o) !== 1'h1 && n < 10)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 10)
      abort();
    rd = (k == 0) ? dmem_rdata_o : far_rdata_o;
  endtask

  task automatic t_timing();
    int lat, fc, base;
    for (int i = 0; i < 27; i++)
    begin
      run_op(tbl[i][19:12], tbl[i][0], lat, fc);
      if (i == 0)
        base = lat;
      cmp(instr_cycles_o, tbl[i][11:8]);
      cmp(instr_bytes_o, tbl[i][5:4]);
      cmp(fc, tbl[i][5:4] - 1);
      cmp(lat - base, (tbl[i][11:8] - 1) * DIV);
      cmp(illegal_o, tbl[i][19:12] == 8'ha5);
      cmp(instr_count_o, i + 1);
    end
  endtask

  task automatic t_stall();
    int lat, fc, base;
    run_op(8'h00, 1'h0, base, fc);
    fork
      run_op(8'ha4, 1'h0, lat, fc);
      begin
        repeat (5) @(negedge mclk_i);
        stall_i = 1'h1;
        repeat (8) @(negedge mclk_i);
        cmp({busy_o, cycle_o}, 5'h11);
        stall_i = 1'h0;
      end
    join
    cmp(instr_cycles_o, 4);
    cmp(lat - base, 3 * DIV + 8);
  endtask

  task automatic t_debug();
    int lat, fc, rdy, hit;
    logic [31:0] c;
    pulse(halt_req_i);
    @(negedge mclk_i);
    cmp(halted_o, 1);
    idle_chk(16'h0000, rdy, hit);
    cmp(rdy, 0);
    pulse(step_req_i);
    run_op(8'h25, 1'h0, lat, fc);
    idle_chk(16'h0000, rdy, hit);
    cmp({halted_o, rdy[7:0]}, 9'h100);
    {bp_idx_i, bp_addr_i, bp_en_i} = {2'h1, 16'h0100, 1'h1};
    pulse(bp_wr_i);
    pulse(run_req_i);
    pc_i = 16'h0040;
    run_op(8'h00, 1'h0, lat, fc);
    idle_chk(16'h0100, rdy, hit);
    cmp({halted_o, rdy[7:0], hit[7:0]}, 17'h10001);
    pulse(run_req_i);
    run_op(8'h04, 1'h0, lat, fc);
    cmp(halted_o, 0);
    bp_en_i = 1'h0;
    pulse(bp_wr_i);
    // A halt during a long instruction waits for its last cycle
    fork
      run_op(8'h84, 1'h0, lat, fc);
      begin
        repeat (6) @(negedge mclk_i);
        pulse(halt_req_i);
        cmp({busy_o, halted_o}, 2'h2);
      end
    join
    cmp({halted_o, instr_cycles_o}, 5'h18);
    c = cycle_count_o;
    repeat (2 * DIV) @(negedge mclk_i);
    cmp(cycle_count_o - c, 0);
    pulse(run_req_i);
    c = cycle_count_o;
    repeat (8 * DIV) @(negedge mclk_i);
    cmp(cycle_count_o - c, 8);
  endtask

  task automatic t_mem();
    logic [7:0] r;
    acc(0, 1, 0, 16'h0030, 8'h3c, r);
    acc(0, 0, 0, 16'h0030, 8'h00, r);
    cmp(r, 8'h3c);
    acc(0, 1, 1, 16'h00c5, 8'h71, r);
    acc(0, 1, 0, 16'h00c5, 8'h99, r);
    acc(0, 0, 1, 16'h00c5, 8'h00, r);
    cmp(r, 8'h71);
    acc(0, 0, 0, 16'h00c5, 8'h00, r);
    cmp(r, 8'h99);
    acc(1, 1, 0, 16'h01ff, 8'ha7, r);
    flash_sel_i = 1'h1;
    acc(1, 1, 0, 16'h01ff, 8'h5e, r);
    acc(1, 0, 0, 16'h01ff, 8'h00, r);
    cmp(r, 8'h5e);
    acc(2, 0, 0, 16'h01ff, 8'h00, r);
    cmp(r, 8'h5e);
    flash_sel_i = 1'h0;
    acc(1, 0, 0, 16'h01ff, 8'h00, r);
    cmp(r, 8'ha7);
  endtask

  initial
  begin
    repeat (16) @(negedge mclk_i);
    resetn_i = 1'h1;
    t_timing();
    t_stall();
    t_debug();
    t_mem();
    conclude();
  end
endmodule
